// >>> hw/rur_core.sv
`timescale 1ns/1ps
// Operation
// - Shift register samples and writes internal registers.
// - Update writes accepted only in factory image.
// - Application read loads control into shift.
// - Factory read loads update into shift.
// - Array reconfiguration copies update register into control.
// - Status records cause; capture copies status.
// - Control, status and shift all on ref clock; user clock sampled.
// - Serial scheme powers up with zero address.
// - Parallel scheme powers up at factory address.
// - Control register is 39 bits, fixed layout.
// - Timeout msbs plus fixed pattern form count.
// - Boot address is address msbs, two zeros.
// - Watchdog enable and oscillator select take effect.
// - Early done check falls back to factory.
// - Status identifies one of five triggers.
// - Factory word: state, zeros, boot address.
// - Info word one: state, enable, timeout.
// - Info word two: state, zeros, boot address.
// - Two history records, current and previous.
// - One-hot sources, highest order wins ties.
// - History flag order, state and boot address.
// - Array request reloads control, restarts configuration.
// - Error triggers clear control, boot address to factory; array loads update.
// - Watchdog counts in application user mode only.
module rur_core
  import rur_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Serial interface from the programmable array.
  input  wire logic        upgrade_shift_clock,
  input  wire logic        upgrade_serial_in,
  input  wire logic        shift_or_load_select,
  input  wire logic        capture_or_update_select,
  input  wire logic        read_select,
  input  wire logic [1:0]  info_select,
  output logic             upgrade_serial_out,
  // Requests from the programmable array.
  input  wire logic        array_reconfig_request,
  input  wire logic        watchdog_reload_request,
  // Configuration pins and loader status.
  input  wire logic        config_reset_pin_n,
  input  wire logic        config_status_pin_n,
  input  wire logic        config_done_pin,
  input  wire logic        crc_error,
  input  wire logic        image_invalid,
  input  wire logic        parallel_scheme,
  input  wire logic        factory_boot_address_instr,
  input  wire logic [21:0] factory_boot_address_msbs,
  // State toward the configuration engine.
  output logic [23:0]      boot_address,
  output logic [1:0]       master_state,
  output logic             reconfig_start,
  output logic             startup_osc_internal,
  output logic             watchdog_running
);

  typedef enum logic [2:0] {
    ST_FACTORY = 3'h1,
    ST_APP_CFG = 3'h2,
    ST_APP_USR = 3'h4
  } rur_state_t;

  localparam int SYNC_W = 38;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 38'h00_0000_0180; // Idle pin levels, so no false edge follows reset.

  logic [SYNC_W-1:0] sync1_q, sync2_q;
  logic [9:0]        prev_q;
  rur_state_t        state_q;
  rur_ctrl_t         ctrl_q, update_q;
  logic [CTRL_W-1:0] shift_q;
  logic [CAUSE_W-1:0] cause_q;
  rur_hist_t         hist1_q, hist2_q;
  logic [WD_W-1:0]   wd_cnt_q;
  logic [4:0]        req_cnt_q, rld_cnt_q;
  logic              req_done_q, rld_done_q;
  logic [2:0]        pwr_q;
  wire               powered_q = pwr_q[2]; // Set once the straps have crossed the synchroniser.

  // Returns the highest-order source of a simultaneous group.
  function automatic logic [CAUSE_W-1:0] top_cause(input logic [CAUSE_W-1:0] c);
    logic [CAUSE_W-1:0] r;
    r = '0;
    for (int i = 0; i < CAUSE_W; i++) begin
      if (c[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  // shift clock sampled
  // Every outside input but rst crosses two flip-flops; the link clock is sampled too.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= {factory_boot_address_msbs, factory_boot_address_instr, parallel_scheme, info_select,
                  image_invalid, crc_error, config_done_pin, config_status_pin_n, config_reset_pin_n,
                  watchdog_reload_request, array_reconfig_request, read_select, capture_or_update_select,
                  shift_or_load_select, upgrade_serial_in, upgrade_shift_clock};
      sync2_q <= sync1_q;
    end
  end

  wire       s_clk   = sync2_q[0];
  wire       s_din   = sync2_q[1];
  wire       s_shift = sync2_q[2];
  wire       s_capt  = sync2_q[3];
  wire       s_read  = sync2_q[4];
  wire       s_req   = sync2_q[5];
  wire       s_rld   = sync2_q[6];
  wire       s_rst_n = sync2_q[7];
  wire       s_stt_n = sync2_q[8];
  wire       s_done  = sync2_q[9];
  wire       s_crc   = sync2_q[10];
  wire       s_inval = sync2_q[11];
  wire [1:0] s_sel   = sync2_q[13:12];
  wire       s_par   = sync2_q[14];
  wire       s_ovr   = sync2_q[15];
  wire [21:0] s_addr = sync2_q[37:16];

  // Delayed copies for edge detection, reset to the idle pin levels.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 10'h180;
    end else begin
      prev_q <= sync2_q[9:0];
    end
  end

  wire clk_rise  = s_clk & ~prev_q[0];
  wire done_rise = s_done & ~prev_q[9];
  wire in_factory = (state_q == ST_FACTORY);
  wire [1:0] ms_code = in_factory ? MS_FACTORY : (state_q == ST_APP_CFG ? MS_APP_CFG : MS_APP_USR);

  // request hold qualify
  // Requests act once held for the least hold time, so short glitches are ignored.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_cnt_q  <= '0;
      req_done_q <= 1'b0;
      rld_cnt_q  <= '0;
      rld_done_q <= 1'b0;
    end else begin
      req_cnt_q  <= s_req ? ((req_cnt_q == 5'(REQ_HOLD_CYC)) ? req_cnt_q : req_cnt_q + 5'h01) : 5'h00;
      req_done_q <= s_req & (req_cnt_q == 5'(REQ_HOLD_CYC - 1) | req_done_q);
      rld_cnt_q  <= s_rld ? ((rld_cnt_q == 5'(REQ_HOLD_CYC)) ? rld_cnt_q : rld_cnt_q + 5'h01) : 5'h00;
      rld_done_q <= s_rld & (rld_cnt_q == 5'(REQ_HOLD_CYC - 1) | rld_done_q);
    end
  end

  wire req_ev = s_req & (req_cnt_q == 5'(REQ_HOLD_CYC - 1)) & ~req_done_q;
  wire rld_ev = s_rld & (rld_cnt_q == 5'(REQ_HOLD_CYC - 1)) & ~rld_done_q;

  wire wd_armed   = (state_q == ST_APP_USR) & ctrl_q.watchdog_enable_bit;
  wire wd_expire  = wd_armed & (wd_cnt_q == '0);
  wire [WD_W-1:0] wd_load = {ctrl_q.watchdog_timeout_msbs, WD_FILL};

  wire early_fail = (state_q == ST_APP_CFG) & ctrl_q.early_done_check & (s_inval | (s_done & ~prev_q[9]
                    & s_inval));

  wire [CAUSE_W-1:0] raw_cause = {~s_rst_n & prev_q[7], s_crc | early_fail, ~s_stt_n & prev_q[8],
                                  wd_expire, req_ev};
  wire [CAUSE_W-1:0] cause_now = top_cause(raw_cause);
  wire               reconfig  = |raw_cause;

  // Power-up address differs by scheme; the strap is taken three cycles after release.
  wire [21:0] factory_msbs = s_par ? (s_ovr ? s_addr : PAR_FACTORY_MSBS) : SER_FACTORY_MSBS;

  // Master state machine.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_FACTORY;
    end else if (reconfig) begin
      state_q <= (cause_now[CAUSE_ARRAY] && in_factory) ? ST_APP_CFG : ST_FACTORY;
    end else if (state_q == ST_APP_CFG && done_rise) begin
      state_q <= ST_APP_USR;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q    <= CTRL_RESET;
      pwr_q     <= 3'h0;
    end else begin
      pwr_q     <= {pwr_q[1:0], 1'b1};
      if (!powered_q) begin
        ctrl_q                   <= CTRL_RESET;
        ctrl_q.boot_address_msbs <= factory_msbs;
      end else if (reconfig) begin
        if (cause_now[CAUSE_ARRAY]) begin
          ctrl_q <= update_q;
        end else begin
          ctrl_q                   <= CTRL_RESET;
          ctrl_q.boot_address_msbs <= factory_msbs;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wd_cnt_q <= '0;
    end else if (!wd_armed || rld_ev) begin
      wd_cnt_q <= wd_load;
    end else if (wd_cnt_q != '0) begin
      wd_cnt_q <= wd_cnt_q - 29'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_q <= '0;
      hist1_q <= '0;
      hist2_q <= '0;
    end else if (reconfig) begin
      cause_q <= cause_now;
      if (!in_factory) begin
        hist2_q <= hist1_q;
        // history record layout
        // State and address are taken live, since the registered outputs lag by one cycle.
        hist1_q <= {1'b0, cause_now, ms_code, ctrl_q.boot_address_msbs, 2'h0};
      end
    end
  end

  // Status words for capture.
  logic [STATUS_W-1:0] status_word;
  always_comb begin
    unique case (s_sel)
      SEL_CURRENT: status_word = in_factory ? {ms_code, 6'h00, boot_address}
                                            : {ms_code, ctrl_q.watchdog_enable_bit, wd_load};
      SEL_INFO2:   status_word = {ms_code, 6'h00, boot_address};
      SEL_HIST1:   status_word = hist1_q;
      default:     status_word = hist2_q;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_q <= '0;
    end else if (clk_rise) begin
      if (s_shift) begin
        shift_q <= {s_din, shift_q[CTRL_W-1:1]};
      end else if (s_capt && s_read) begin
        shift_q <= in_factory ? update_q : ctrl_q;
      end else if (s_capt) begin
        shift_q <= {7'h00, status_word};
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      update_q <= CTRL_RESET;
    end else if (clk_rise && !s_shift && !s_capt && in_factory) begin
      update_q <= shift_q;
    end
  end

  // Registered outputs.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upgrade_serial_out   <= 1'b0;
      boot_address         <= '0;
      master_state         <= MS_FACTORY;
      reconfig_start       <= 1'b0;
      startup_osc_internal <= 1'b0;
      watchdog_running     <= 1'b0;
    end else begin
      upgrade_serial_out   <= shift_q[0];
      boot_address         <= {ctrl_q.boot_address_msbs, 2'h0};
      master_state         <= ms_code;
      reconfig_start       <= reconfig;
      startup_osc_internal <= ctrl_q.osc_select;
      watchdog_running     <= wd_armed;
    end
  end

  // Checks.
  chk_update_guard: assert property (@(posedge ref_clk) disable iff (rst)
    (!in_factory) |=> $stable(update_q) || $past(in_factory))
    else $error("Update register changed outside factory image.");

  chk_app_read: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_rise && !s_shift && s_capt && s_read && !in_factory) |=> (shift_q == $past(ctrl_q)))
    else $error("Application read did not load control.");

  chk_factory_read: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_rise && !s_shift && s_capt && s_read && in_factory) |=> (shift_q == $past(update_q)))
    else $error("Factory read did not load update register.");

  chk_array_load: assert property (@(posedge ref_clk) disable iff (rst)
    (powered_q && reconfig && cause_now[CAUSE_ARRAY]) |=> (ctrl_q == $past(update_q)))
    else $error("Array reconfiguration did not copy update register.");

  chk_error_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (powered_q && reconfig && !cause_now[CAUSE_ARRAY]) |=> (ctrl_q.watchdog_timeout_msbs == 12'h000
    && !ctrl_q.watchdog_enable_bit && !ctrl_q.early_done_check))
    else $error("Error trigger did not clear control register.");

  chk_cause_onehot: assert property (@(posedge ref_clk) disable iff (rst)
    reconfig |=> $onehot(cause_q) && (cause_q[CAUSE_EXT] == $past(raw_cause[CAUSE_EXT])))
    else $error("Recorded cause is not the highest-order source.");

  chk_wd_idle: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q != ST_APP_USR) |=> (wd_cnt_q == $past(wd_load)))
    else $error("Watchdog moved outside application user mode.");

  chk_wd_timeout: assert property (@(posedge ref_clk) disable iff (rst)
    wd_expire |=> (state_q == ST_FACTORY) && reconfig_start
    && (cause_q[CAUSE_WD] || $past(|raw_cause[CAUSE_EXT:CAUSE_STAT])))
    else $error("Watchdog expiry did not load factory image.");

  chk_req_hold: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(s_req) ##1 s_req [*8] |-> !cause_q[CAUSE_ARRAY] || $past(cause_q[CAUSE_ARRAY], 9))
    else $error("Array request acted before its hold time.");

  chk_boot_addr: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 (boot_address == {$past(ctrl_q.boot_address_msbs), 2'h0}))
    else $error("Boot address does not follow control register.");

endmodule

// >>> hw/rur_pkg.sv
package rur_pkg;

  // Control word layout, shared by the control and update registers.
  typedef struct packed {
    logic        reserved_high_bit;
    logic        early_done_check;
    logic        osc_select;
    logic        watchdog_enable_bit;
    logic        reserved_low_bit;
    logic [21:0] boot_address_msbs;
    logic [11:0] watchdog_timeout_msbs;
  } rur_ctrl_t;

  // One history record; sources are one-hot, highest order wins.
  typedef struct packed {
    logic        unused_top;
    logic        src_ext_reset;
    logic        src_crc;
    logic        src_status_pin;
    logic        src_watchdog;
    logic        src_array;
    logic [1:0]  master_state;
    logic [23:0] boot_address;
  } rur_hist_t;

  // Widths.
  localparam int CTRL_W   = 39;
  localparam int STATUS_W = 32;
  localparam int WD_W     = 29;
  localparam int CAUSE_W  = 5;

  // Cause vector bit positions, ordered as in the history record.
  localparam int CAUSE_EXT   = 4;
  localparam int CAUSE_CRC   = 3;
  localparam int CAUSE_STAT  = 2;
  localparam int CAUSE_WD    = 1;
  localparam int CAUSE_ARRAY = 0;

  // Watchdog fill pattern below the timeout field.
  localparam logic [16:0] WD_FILL = 17'h00008;

  // Power-up factory address msbs for the parallel-flash scheme (24'h010000 >> 2).
  localparam logic [21:0] PAR_FACTORY_MSBS = 22'h004000;
  localparam logic [21:0] SER_FACTORY_MSBS = 22'h000000;

  // Master state codes as reported in status words.
  localparam logic [1:0] MS_FACTORY = 2'h0;
  localparam logic [1:0] MS_APP_CFG = 2'h1;
  localparam logic [1:0] MS_APP_USR = 2'h2;

  // Capture word selections.
  localparam logic [1:0] SEL_CURRENT = 2'h0;
  localparam logic [1:0] SEL_INFO2   = 2'h1;
  localparam logic [1:0] SEL_HIST1   = 2'h2;

  // Least hold time of array request and watchdog reload.
  localparam int CLK_PERIOD_NS = 10;
  localparam int REQ_HOLD_NS   = 250;
  localparam int REQ_HOLD_CYC  = (REQ_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reset value of the control register before power-up load.
  localparam logic [CTRL_W-1:0] CTRL_RESET = 39'h00_0000_0000;

endpackage

// >>> tb/rur_user_model.sv
`timescale 1ns/1ps
module rur_user_model (
  // Clock and serial return.
  input  wire logic ref_clk,
  input  wire logic upgrade_serial_out,
  // Serial interface.
  output logic       upgrade_shift_clock,
  output logic       upgrade_serial_in,
  output logic       shift_or_load_select,
  output logic       capture_or_update_select,
  output logic       read_select,
  output logic [1:0] info_select,
  // Requests.
  output logic       array_reconfig_request,
  output logic       watchdog_reload_request
);
  // The shift clock rests low between frames.
  initial begin
    {upgrade_shift_clock, upgrade_serial_in, shift_or_load_select} = 3'h0;
    {capture_or_update_select, read_select, info_select} = 4'h0;
    {array_reconfig_request, watchdog_reload_request} = 2'h0;
  end
  task automatic half();
    repeat (8) @(negedge ref_clk);
  endtask
  // One pulse; controls stay put long around it.
  task automatic tick();
    upgrade_shift_clock = 1'b1;
    half();
    upgrade_shift_clock = 1'b0;
  endtask
  task automatic xfer(input logic [38:0] din, output logic [38:0] dout);
    shift_or_load_select = 1'b1;
    for (int i = 0; i < 39; i++) begin
      upgrade_serial_in = din[i];
      half();
      dout[i] = upgrade_serial_out;
      tick();
    end
    upgrade_serial_in = ~din[38];
  endtask
  // Load operation, capture or update.
  task automatic load(input logic cap, input logic rd, input logic [1:0] sel);
    shift_or_load_select = 1'b0;
    capture_or_update_select = cap;
    read_select = rd;
    info_select = sel;
    half();
    tick();
  endtask
  task automatic wr_update(input logic [38:0] v);
    logic [38:0] unused;
    xfer(v, unused);
    load(1'b0, 1'b0, 2'h0);
  endtask
  task automatic request();
    array_reconfig_request = 1'b1;
    repeat (30) @(negedge ref_clk);
    array_reconfig_request = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import rur_pkg::*;
;
  // Clock, reset and pins.
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_rst_n = 1'b1;
  logic        cfg_stat_n = 1'b1;
  logic        done = 1'b0;
  logic        crc = 1'b0;
  logic        inval = 1'b0;
  logic        par = 1'b0;
  logic        ovr = 1'b0;
  logic [21:0] ovr_msbs = 22'h000000;
  logic        sclk, sdin, sout, shs, cus, rds, arq, wdr;
  logic [1:0]  inf, mstate;
  logic [23:0] boot;
  logic        rstart, osc, wdrun;
  int          error_cnt = 0;
  int          n_tests = 0;
  logic [31:0] rnd = 32'h359846BA;
  logic [7:0]  pulses = 8'h00;
  logic [7:0]  p0;
  logic [38:0] dout, exp_h, prev;
  rur_ctrl_t   c;

  // 100 MHz clock.
  always #5 ref_clk = ~ref_clk;
  // Count start pulses to prove one action per request.
  always @(posedge ref_clk) if (rstart === 1'b1) pulses <= pulses + 8'h01;

  rur_core i_dut (.ref_clk(ref_clk), .rst(rst), .upgrade_shift_clock(sclk), .upgrade_serial_in(sdin),
    .shift_or_load_select(shs), .capture_or_update_select(cus), .read_select(rds), .info_select(inf),
    .upgrade_serial_out(sout), .array_reconfig_request(arq), .watchdog_reload_request(wdr),
    .config_reset_pin_n(cfg_rst_n), .config_status_pin_n(cfg_stat_n), .config_done_pin(done),
    .crc_error(crc), .image_invalid(inval), .parallel_scheme(par), .factory_boot_address_instr(ovr),
    .factory_boot_address_msbs(ovr_msbs), .boot_address(boot), .master_state(mstate),
    .reconfig_start(rstart), .startup_osc_internal(osc), .watchdog_running(wdrun));
  rur_user_model i_user (.ref_clk(ref_clk), .upgrade_serial_out(sout), .upgrade_shift_clock(sclk),
    .upgrade_serial_in(sdin), .shift_or_load_select(shs), .capture_or_update_select(cus),
    .read_select(rds), .info_select(inf), .array_reconfig_request(arq), .watchdog_reload_request(wdr));

  // Verdict in one place.
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [38:0] seen, input logic [38:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic rur_ctrl_t rnd_ctrl();
    rur_ctrl_t v;
    rnd = lfsr(lfsr(rnd));
    v = {rnd[6:0], rnd};
    v.early_done_check = 1'b1;
    v.osc_select = 1'b1;
    v.watchdog_enable_bit = 1'b0;
    v.reserved_high_bit = 1'b0;
    v.reserved_low_bit = 1'b0;
    return v;
  endfunction
  function automatic logic [23:0] ba(input rur_ctrl_t v);
    return {v.boot_address_msbs, 2'b00};
  endfunction
  function automatic logic [38:0] word(input logic [1:0] st, input logic [23:0] a);
    return {7'h00, st, 6'h00, a};
  endfunction
  function automatic logic [38:0] hist(input logic [4:0] src, input logic [1:0] st, input logic [23:0] a);
    return {8'h00, src, st, a};
  endfunction
  // Bounded wait for a master state; a hang ends the run.
  task automatic wait_state(input logic [1:0] st);
    int k;
    for (k = 0; k < 300 && mstate !== st; k++)
      @(negedge ref_clk);
    if (k == 300) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  // Capture or read a word and shift it out whole.
  task automatic cap(input logic rd, input logic [1:0] sel, input logic [38:0] exp);
    i_user.load(1'b1, rd, sel);
    rnd = lfsr(rnd);
    i_user.xfer({rnd[6:0], rnd}, dout);
    check(dout, exp);
  endtask
  // Factory writes, reads back, then launches and completes an application.
  task automatic go_app(input rur_ctrl_t v);
    i_user.wr_update(v);
    cap(1'b1, SEL_CURRENT, v);
    p0 = pulses;
    i_user.request();
    check(pulses - p0, 39'h1);
    wait_state(MS_APP_CFG);
    check(boot, ba(v));
    check(osc, v.osc_select);
    done = 1'b1;
    wait_state(MS_APP_USR);
    @(negedge ref_clk);
    check(wdrun, v.watchdog_enable_bit);
    done = 1'b0;
  endtask

  // Main sequence; inputs change on the falling edge.
  initial begin
    for (int k = 2; k >= 0; k--) begin
      rnd = lfsr(rnd);
      par = (k != 0);
      ovr = (k == 2);
      ovr_msbs = rnd[21:0];
      rst = 1'b1;
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      check(boot, k == 2 ? {rnd[21:0], 2'b00} : (k == 1 ? 24'h010000 : 24'h000000));
    end
    cap(1'b0, SEL_CURRENT, word(MS_FACTORY, 24'h000000));
    $display("test power_up done");
    for (int r = 0; r < 3; r++) begin
      c = rnd_ctrl();
      go_app(c);
      cap(1'b0, SEL_CURRENT, {7'h00, MS_APP_USR, 1'b0, c.watchdog_timeout_msbs, 17'h00008});
      cap(1'b0, SEL_INFO2, word(MS_APP_USR, ba(c)));
      cap(1'b1, SEL_CURRENT, c);
      i_user.wr_update(~c);
      case (r)
        0: i_user.request();
        1: begin
          crc = 1'b1;
          cfg_stat_n = 1'b0;
          @(negedge ref_clk);
          crc = 1'b0;
        end
        default: cfg_rst_n = 1'b0;
      endcase
      wait_state(MS_FACTORY);
      repeat (30) @(negedge ref_clk);
      cfg_stat_n = 1'b1;
      cfg_rst_n = 1'b1;
      check(boot, r == 0 ? ba(c) : 24'h000000);
      cap(1'b1, SEL_CURRENT, c);
      exp_h = hist(r == 0 ? 5'h01 : (r == 1 ? 5'h08 : 5'h10), MS_APP_USR, ba(c));
      cap(1'b0, SEL_HIST1, exp_h);
      if (r > 0)
        cap(1'b0, 2'h3, prev);
      prev = exp_h;
      $display("test round %0d done", r);
    end
    c = rnd_ctrl();
    c.watchdog_enable_bit = 1'b1;
    c.watchdog_timeout_msbs = 12'h000;
    go_app(c);
    wait_state(MS_FACTORY);
    check(boot, 24'h000000);
    cap(1'b0, SEL_HIST1, hist(5'h02, MS_APP_USR, ba(c)));
    $display("test watchdog done");
    c = rnd_ctrl();
    i_user.wr_update(c);
    inval = 1'b1;
    i_user.request();
    wait_state(MS_FACTORY);
    inval = 1'b0;
    cap(1'b0, SEL_HIST1, hist(5'h08, MS_APP_CFG, ba(c)));
    $display("test early_check done");
    report_and_stop();
  end
  // Hard stop if the run hangs.
  initial begin
    #1000000;
    error_cnt++;
    report_and_stop();
  end
endmodule
